// File: bench/cms_channel_map_test.sv
// self-checking testbench for the channel-two map register block
`timescale 1ns/1ps
module cms_channel_map_test;
	// *****************************************************************
	// signals
	// *****************************************************************
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0]  oce = 4'h0;
	logic        cdone = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [1:0]  act;
	logic        conv;
	logic        two_act;
	logic [1:0]  app;
	logic        en;
	logic [1:0]  setup;
	logic [4:0]  pos;
	logic [4:0]  neg;
	int          err_count = 0;
	int          compares = 0;
	int          cyc = 0;
	logic [31:0] seed = 32'h0000001f;
	logic [31:0] rd;
	logic [31:0] v;
	logic        e;
	logic [1:0]  exp_ch;

	always #5 pclk = ~pclk;

	cms_channel_map cms_channel_map_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.other_channel_enables(oce), .conversion_done(cdone), .active_channel(act),
		.converting(conv), .channel_two_active(two_act), .applied_setup(app),
		.channel_two_enable(en), .channel_two_setup_choice(setup),
		.channel_two_positive_input_select(pos), .channel_two_negative_input_select(neg)
	);

	// *****************************************************************
	// helpers
	// *****************************************************************
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// next enabled channel after the current one, wrapping
	function automatic logic [1:0] nxt(input logic [1:0] c, input logic [3:0] m);
		logic [1:0] k;
		for (int i = 1; i <= 4; i++) begin
			k = c + 2'(i);
			if (m[k]) return k;
		end
		return c;
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		compares++;
		if (g !== x) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic stop_test();
		$display("err_count=%0d compares=%0d", err_count, compares);
		if (err_count == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			stop_test();
		end
	end

	// *****************************************************************
	// main sequence
	// *****************************************************************
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, cms_pkg::MAP_ADDR, 32'h0, rd, e);
		chk(rd, 32'h00000001);
		chk(32'({en, setup, pos, neg}), 32'h00000001);
		for (int i = 0; i < 12; i++) begin
			v = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h000002b6 : (rnd() & 32'h0000b3ff);
			apb(1'b1, cms_pkg::MAP_ADDR, v, rd, e);
			chk(32'(e), 32'h0);
			apb(1'b0, cms_pkg::MAP_ADDR, 32'h0, rd, e);
			chk(rd, v & 32'h0000b3ff);
			chk(32'({en, setup, pos, neg}), 32'({v[15], v[13:12], v[9:5], v[4:0]}));
		end
		// index used as byte address, then a neighbour word
		apb(1'b1, 8'h12, rnd(), rd, e);
		chk(32'(e), 32'h1);
		apb(1'b0, 8'h4c, 32'h0, rd, e);
		chk(rd, 32'h0);
		chk(32'(e), 32'h1);
		apb(1'b0, cms_pkg::MAP_ADDR, 32'h0, rd, e);
		chk(rd, v & 32'h0000b3ff);
		// only channel two enabled, every setup code
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, cms_pkg::MAP_ADDR, 32'h00008000 | (32'(s) << 12), rd, e);
			repeat (4) @(posedge pclk);
			chk(32'({act, two_act, conv}), 32'h0000000b);
			chk(32'(app), 32'(s));
		end
		// several channels enabled, step on each finished conversion
		oce <= 4'hb;
		exp_ch = 2'h2;
		for (int i = 0; i < 6; i++) begin
			@(posedge pclk);
			cdone <= 1'b1;
			@(posedge pclk);
			cdone <= 1'b0;
			repeat (3) @(posedge pclk);
			exp_ch = nxt(exp_ch, 4'hf);
			chk(32'({act, two_act}), 32'({exp_ch, exp_ch == 2'h2}));
			chk(32'(app), 32'h3);
		end
		oce <= 4'h0;
		apb(1'b1, cms_pkg::MAP_ADDR, 32'h0, rd, e);
		repeat (4) @(posedge pclk);
		chk(32'({conv, two_act}), 32'h0);
		// reset in mid-run brings every field back
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, cms_pkg::MAP_ADDR, 32'h0, rd, e);
		chk(rd, 32'(cms_pkg::MAP_RESET));
		chk(32'({act, conv, two_act, app}), 32'h0);
		stop_test();
	end
endmodule

// File: rtl/cms_channel_map.sv
// channel-two map register with apb access and channel sequencing
// *****************************************************************
// Functional notes
// - the channel-two map is a 16-bit register at index 0x12 that resets to 0x0001.
// - bit 15 enables channel two for conversion and resets to 0.
// - with two or more channels enabled the converter steps through them on its own.
// - bits 13:12 choose setup 0 to 3 for channel two and reset to 00.
// - while channel two converts its chosen setup is applied as one group of four registers.
// - bits 9:5 route an input to the positive input, codes 0 to 4 or 10101, reset input 0.
// - bits 4:0 route an input to the negative input, adding 10110, reset to 00001.
// *****************************************************************
`timescale 1ns/1ps
module cms_channel_map (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// sequencer side
	input  wire logic [3:0]  other_channel_enables,
	input  wire logic        conversion_done,
	output logic      [1:0]  active_channel,
	output logic             converting,
	output logic             channel_two_active,
	output logic      [1:0]  applied_setup,
	// channel-two fields
	output logic             channel_two_enable,
	output logic      [1:0]  channel_two_setup_choice,
	output logic      [4:0]  channel_two_positive_input_select,
	output logic      [4:0]  channel_two_negative_input_select
);
	// *************************************************************
	// state
	// *************************************************************
	typedef struct packed {
		logic        en;
		logic [1:0]  setup;
		logic [4:0]  pos;
		logic [4:0]  neg;
		logic        ready;
		logic        err;
		logic [31:0] rdata;
		logic [1:0]  chan;
		logic        conv;
		logic        two_act;
		logic [1:0]  applied;
	} cms_state_s;

	cms_state_s state_reg;
	cms_state_s state_next;
	logic [15:0] map_value;
	logic [3:0]  all_enables;
	logic [3:0]  enables_next;
	logic [1:0]  seq_next;
	logic        hit;
	logic        access;
	logic        do_write;

	// reserved bits read as zero
	assign map_value = {state_reg.en, 1'b0, state_reg.setup, 2'b00,
		state_reg.pos, state_reg.neg};
	assign hit = (paddr == cms_pkg::MAP_ADDR);
	assign access = psel && penable && state_reg.ready;
	assign do_write = access && pwrite && hit;
	assign all_enables = {other_channel_enables[3], state_reg.en,
		other_channel_enables[1:0]};
	// enable mask after this edge, kept out of the next-state process
	assign enables_next = {other_channel_enables[3],
		(do_write ? pwdata[cms_pkg::EN_BIT] : state_reg.en),
		other_channel_enables[1:0]};

	cms_next_channel #(
		.N (cms_pkg::NUM_CHANNELS)
	) cms_next_channel_i (
		.enables      (enables_next),
		.current      (state_reg.chan),
		.next_channel (seq_next)
	);

	// *************************************************************
	// next-state logic
	// *************************************************************
	always_comb begin
		logic [15:0] wval;
		wval = pwdata[15:0] & cms_pkg::MAP_WMASK;
		state_next = state_reg;
		// one wait state: ready rises in the second access cycle
		state_next.ready = psel && penable && !state_reg.ready;
		state_next.err = psel && penable && !state_reg.ready && !hit;
		state_next.rdata = cms_pkg::RDATA_IDLE;
		if (psel && penable && !state_reg.ready && !pwrite && hit) begin
			state_next.rdata = {16'h0000, map_value};
		end
		if (do_write) begin
			state_next.en = wval[cms_pkg::EN_BIT];
			state_next.setup = wval[cms_pkg::SETUP_HI:cms_pkg::SETUP_LO];
			state_next.pos = wval[cms_pkg::POS_HI:cms_pkg::POS_LO];
			state_next.neg = wval[cms_pkg::NEG_HI:cms_pkg::NEG_LO];
		end
		// step on each finished conversion, or leave a channel now disabled
		if (conversion_done || !enables_next[state_reg.chan]) begin
			state_next.chan = seq_next;
		end
		state_next.conv = |enables_next;
		state_next.two_act = state_next.en && (state_next.chan == cms_pkg::THIS_CHANNEL);
		if (state_next.two_act) begin
			state_next.applied = state_next.setup;
		end
	end

	// *************************************************************
	// registers
	// *************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg.en <= cms_pkg::MAP_RESET[cms_pkg::EN_BIT];
			state_reg.setup <= cms_pkg::SETUP_RESET;
			state_reg.pos <= cms_pkg::POS_RESET;
			state_reg.neg <= cms_pkg::NEG_RESET;
			state_reg.ready <= 1'b0;
			state_reg.err <= 1'b0;
			state_reg.rdata <= cms_pkg::RDATA_IDLE;
			state_reg.chan <= 2'h0;
			state_reg.conv <= 1'b0;
			state_reg.two_act <= 1'b0;
			state_reg.applied <= cms_pkg::SETUP_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign prdata = state_reg.rdata;
	assign pready = state_reg.ready;
	assign pslverr = state_reg.err;
	assign active_channel = state_reg.chan;
	assign converting = state_reg.conv;
	assign channel_two_active = state_reg.two_act;
	assign applied_setup = state_reg.applied;
	assign channel_two_enable = state_reg.en;
	assign channel_two_setup_choice = state_reg.setup;
	assign channel_two_positive_input_select = state_reg.pos;
	assign channel_two_negative_input_select = state_reg.neg;

	// *************************************************************
	// assertions
	// *************************************************************
	sequence s_setup_phase;
		psel && !penable;
	endsequence

	sequence s_map_write;
		psel && penable && pready && pwrite && (paddr == cms_pkg::MAP_ADDR);
	endsequence

	property p_answer;
		@(posedge pclk) disable iff (!presetn)
		s_setup_phase ##1 (psel && penable) |-> ##1 pready;
	endproperty
	a_answer: assert property (p_answer) else $error("no answer one cycle into access");

	property p_write_lands;
		@(posedge pclk) disable iff (!presetn)
		s_map_write |=> (map_value == ($past(pwdata[15:0]) & cms_pkg::MAP_WMASK));
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("map write not stored");

	property p_rsv_zero;
		@(posedge pclk) disable iff (!presetn)
		pready && !pwrite && !pslverr |-> (prdata[cms_pkg::RSV_BIT] == 1'b0)
			&& (prdata[cms_pkg::RSV_HI:cms_pkg::RSV_LO] == 2'b00) && (prdata[31:16] == 16'h0000);
	endproperty
	a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits read nonzero");

	property p_disabled_skip;
		@(posedge pclk) disable iff (!presetn)
		!channel_two_enable |-> !channel_two_active;
	endproperty
	a_disabled_skip: assert property (p_disabled_skip) else $error("disabled channel active");

	property p_step;
		@(posedge pclk) disable iff (!presetn)
		conversion_done
			&& !(psel && penable && pready && pwrite && (paddr == cms_pkg::MAP_ADDR))
			&& ($countones(all_enables) > 1)
			&& all_enables[active_channel] && (other_channel_enables == $past(other_channel_enables))
			|=> (active_channel != $past(active_channel));
	endproperty
	a_step: assert property (p_step) else $error("sequencer did not step");

	property p_setup_applied;
		@(posedge pclk) disable iff (!presetn)
		channel_two_active |-> (applied_setup == channel_two_setup_choice);
	endproperty
	a_setup_applied: assert property (p_setup_applied) else $error("wrong setup applied");

	property p_setup_field;
		@(posedge pclk) disable iff (!presetn)
		s_map_write |=> (channel_two_setup_choice == $past(pwdata[13:12]));
	endproperty
	a_setup_field: assert property (p_setup_field) else $error("setup choice not written");

	property p_pos_field;
		@(posedge pclk) disable iff (!presetn)
		s_map_write |=> (channel_two_positive_input_select == $past(pwdata[9:5]));
	endproperty
	a_pos_field: assert property (p_pos_field) else $error("positive select not written");

	property p_neg_field;
		@(posedge pclk) disable iff (!presetn)
		s_map_write |=> (channel_two_negative_input_select == $past(pwdata[4:0]));
	endproperty
	a_neg_field: assert property (p_neg_field) else $error("negative select not written");
endmodule

// File: rtl/cms_next_channel.sv
// picks the next enabled channel after the current one, wrapping around
`timescale 1ns/1ps
module cms_next_channel #(
	parameter int N = 4
) (
	// channel state
	input  wire logic [N-1:0]         enables,
	input  wire logic [$clog2(N)-1:0] current,
	// result
	output logic      [$clog2(N)-1:0] next_channel
);
	always_comb begin
		logic [$clog2(N)-1:0] cand;
		logic                 found;
		cand = current;
		found = 1'b0;
		next_channel = current;
		for (int i = 1; i <= N; i++) begin
			cand = current + ($clog2(N))'(i);
			if (!found && enables[cand]) begin
				next_channel = cand;
				found = 1'b1;
			end
		end
	end
endmodule

// File: rtl/cms_pkg.sv
// constants for the channel-two map register block
package cms_pkg;
	localparam int          NUM_CHANNELS  = 4;
	localparam logic [7:0]  MAP_INDEX     = 8'h12;
	localparam logic [7:0]  MAP_ADDR      = 8'(MAP_INDEX * 4);
	localparam logic [15:0] MAP_RESET     = 16'h0001;
	localparam logic [15:0] MAP_WMASK     = 16'hb3ff;
	localparam int          EN_BIT        = 15;
	localparam int          RSV_BIT       = 14;
	localparam int          SETUP_HI      = 13;
	localparam int          SETUP_LO      = 12;
	localparam int          RSV_HI        = 11;
	localparam int          RSV_LO        = 10;
	localparam int          POS_HI        = 9;
	localparam int          POS_LO        = 5;
	localparam int          NEG_HI        = 4;
	localparam int          NEG_LO        = 0;
	localparam logic [1:0]  THIS_CHANNEL  = 2'h2;
	localparam logic [1:0]  SETUP_RESET   = 2'h0;
	localparam logic [4:0]  POS_RESET     = 5'h00;
	localparam logic [4:0]  NEG_RESET     = 5'h01;
	localparam logic [4:0]  INPUT_LAST    = 5'h04;
	localparam logic [4:0]  POS_REF_CODE  = 5'h15;
	localparam logic [4:0]  NEG_REF_CODE  = 5'h16;
	localparam logic [31:0] RDATA_IDLE    = 32'h00000000;
endpackage
